//--- dcg_pkg.sv
/*
  Package for the converter clear gating block: register offsets, field
  positions, reset values and widths.
  Assumes an 8-bit register port with byte addresses as printed.
*/
package dcg_pkg;
  localparam int unsigned DCG_ADDR_W = 8;
  localparam int unsigned DCG_DATA_W = 8;
  localparam int unsigned DCG_NUM_CH = 16;
  localparam int unsigned DCG_NUM_ADC = 5;
  localparam int unsigned DCG_NUM_MISC = 4;
  localparam int unsigned DCG_NUM_ALARM = DCG_NUM_ADC + DCG_NUM_MISC;
  // Register offsets
  localparam logic [7:0] DCG_CLR_EN_LOW_ADDR = 8'h18;
  localparam logic [7:0] DCG_CLR_EN_HIGH_ADDR = 8'h19;
  localparam logic [7:0] DCG_CLR_SRC_ADC_ADDR = 8'h1a;
  localparam logic [7:0] DCG_CLR_SRC_MISC_ADDR = 8'h1b;
  localparam logic [7:0] DCG_ALARM_STAT_ADDR = 8'h1f;
  localparam logic [7:0] DCG_CTRL_ADDR = 8'h1d;
  localparam logic [7:0] DCG_CLR_STAT_LOW_ADDR = 8'h20;
  localparam logic [7:0] DCG_CLR_STAT_HIGH_ADDR = 8'h21;
  localparam logic [7:0] DCG_ALARM_STAT_HI_ADDR = 8'h22;
  // Writable bit masks; reserved bits store zero
  localparam logic [7:0] DCG_SRC_ADC_MASK = 8'h1f;
  localparam logic [7:0] DCG_SRC_MISC_MASK = 8'h0f;
  // Misc source field positions
  localparam int unsigned DCG_EXT_PIN_BIT = 3;
  localparam int unsigned DCG_THERM_BIT = 2;
  localparam int unsigned DCG_LT_HIGH_BIT = 1;
  localparam int unsigned DCG_LT_LOW_BIT = 0;
  // Control register field: alarm latch disable
  localparam int unsigned DCG_LATCH_DIS_BIT = 4;
  localparam logic [7:0] DCG_RESET_VAL = 8'h00;
endpackage : dcg_pkg

//--- dcg_alarm_latch.sv
/*
  Alarm flag holder: one flag per alarm source, sticky or following.
  Assumes alarm conditions are already in the sys_clk domain.
*/
`timescale 1ns/1ps
module dcg_alarm_latch
  import dcg_pkg::*;
#(
  parameter int unsigned N = DCG_NUM_ALARM
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N-1:0] cond,
  input wire logic latch_disable,
  input wire logic read_clear,
  output logic [N-1:0] flag_q
);
  typedef struct packed {
    logic [N-1:0] flag;
  } dcg_latch_type;
  dcg_latch_type s_q;
  dcg_latch_type s_d;

  // Set beats the read clear, so a new alarm is never lost
  always_comb begin
    s_d = s_q;
    if (latch_disable) begin
      s_d.flag = cond;
    end else if (read_clear) begin
      s_d.flag = cond;
    end else begin
      s_d.flag = s_q.flag | cond;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_q = s_q.flag;

  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!latch_disable && !read_clear && flag_q != '0) |=>
      ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("Latched alarm flag dropped without read");
  follow_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    latch_disable |=> flag_q == $past(cond))
    else $error("Alarm flag not following condition");
endmodule : dcg_alarm_latch

//--- dcg_clear_gate.sv
/*
  Converter clear gating: clear enables, clear source selects, alarm
  flags and the per-channel forced clear outputs, on a simple register
  port (address, write data, write and read strobes, data next cycle).
  Assumes alarm inputs come from other clock domains or pins and are
  synchronised here; strobes are never both high at once.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module dcg_clear_gate
  import dcg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [DCG_ADDR_W-1:0] reg_addr,
  input wire logic [DCG_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DCG_DATA_W-1:0] reg_rdata,
  input wire logic [DCG_NUM_ADC-1:0] input_alarm,
  input wire logic external_alarm_input_pin,
  input wire logic thermal_alarm,
  input wire logic local_temp_high_alarm,
  input wire logic local_temp_low_alarm,
  input wire logic auto_mode,
  output logic [DCG_NUM_CH-1:0] channel_clear,
  output logic clear_event
);
  localparam int unsigned NA = DCG_NUM_ALARM;
  localparam int unsigned HALF = DCG_NUM_CH / 2;

  typedef struct packed {
    logic [DCG_NUM_CH-1:0] channel_clear_enable;
    logic [DCG_DATA_W-1:0] src_adc;
    logic [DCG_DATA_W-1:0] src_misc;
    logic alarm_latch_disable;
    logic [NA-1:0] sync1;
    logic [NA-1:0] sync2;
    logic [DCG_DATA_W-1:0] rdata;
    logic [DCG_NUM_CH-1:0] clr;
    logic evt;
  } dcg_state_type;

  dcg_state_type s_q;
  dcg_state_type s_d;
  logic [NA-1:0] raw_alarm;
  logic [NA-1:0] flag;
  logic [NA-1:0] select;
  logic stat_read;
  logic evt_now;

  // Alarm vector: inputs in bits 0-4 low, misc sources above in bits 5-8
  assign raw_alarm = {external_alarm_input_pin, thermal_alarm,
                      local_temp_high_alarm, local_temp_low_alarm,
                      input_alarm};
  assign select = {s_q.src_misc[DCG_NUM_MISC-1:0],
                   s_q.src_adc[DCG_NUM_ADC-1:0]};
  // Reading either status register releases the latched flags
  assign stat_read = reg_read && (reg_addr == DCG_ALARM_STAT_ADDR ||
                                  reg_addr == DCG_ALARM_STAT_HI_ADDR);

  dcg_alarm_latch #(
    .N(NA)
  ) u_latch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cond(s_q.sync2),
    .latch_disable(s_q.alarm_latch_disable),
    .read_clear(stat_read),
    .flag_q(flag)
  );

  // Clear event from selected flags; operating mode is not looked at
  assign evt_now = |(flag & select);

  // Next state: sync, register writes, read mux, clear outputs
  always_comb begin
    s_d = s_q;
    s_d.sync1 = raw_alarm;
    s_d.sync2 = s_q.sync1;
    s_d.rdata = DCG_RESET_VAL;
    if (reg_write) begin
      if (reg_addr == DCG_CLR_EN_LOW_ADDR) begin
        s_d.channel_clear_enable[HALF-1:0] = reg_wdata;
      end else if (reg_addr == DCG_CLR_EN_HIGH_ADDR) begin
        s_d.channel_clear_enable[DCG_NUM_CH-1:HALF] = reg_wdata;
      end else if (reg_addr == DCG_CLR_SRC_ADC_ADDR) begin
        s_d.src_adc = reg_wdata & DCG_SRC_ADC_MASK;
      end else if (reg_addr == DCG_CLR_SRC_MISC_ADDR) begin
        s_d.src_misc = reg_wdata & DCG_SRC_MISC_MASK;
      end else if (reg_addr == DCG_CTRL_ADDR) begin
        s_d.alarm_latch_disable = reg_wdata[DCG_LATCH_DIS_BIT];
      end
    end
    if (reg_read) begin
      if (reg_addr == DCG_CLR_EN_LOW_ADDR) begin
        s_d.rdata = s_q.channel_clear_enable[HALF-1:0];
      end else if (reg_addr == DCG_CLR_EN_HIGH_ADDR) begin
        s_d.rdata = s_q.channel_clear_enable[DCG_NUM_CH-1:HALF];
      end else if (reg_addr == DCG_CLR_SRC_ADC_ADDR) begin
        s_d.rdata = s_q.src_adc;
      end else if (reg_addr == DCG_CLR_SRC_MISC_ADDR) begin
        s_d.rdata = s_q.src_misc;
      end else if (reg_addr == DCG_CTRL_ADDR) begin
        s_d.rdata[DCG_LATCH_DIS_BIT] = s_q.alarm_latch_disable;
      end else if (reg_addr == DCG_ALARM_STAT_ADDR) begin
        s_d.rdata = flag[DCG_DATA_W-1:0];
      end else if (reg_addr == DCG_ALARM_STAT_HI_ADDR) begin
        s_d.rdata = {{(2*DCG_DATA_W-NA){1'b0}}, flag[NA-1:DCG_DATA_W]};
      end else if (reg_addr == DCG_CLR_STAT_LOW_ADDR) begin
        s_d.rdata = s_q.clr[HALF-1:0];
      end else if (reg_addr == DCG_CLR_STAT_HIGH_ADDR) begin
        s_d.rdata = s_q.clr[DCG_NUM_CH-1:HALF];
      end
    end
    s_d.evt = evt_now;
    // Enabled channels forced clear, others left alone
    s_d.clr = evt_now ? s_q.channel_clear_enable
                      : '0;
  end

  // One register for all state but the alarm flags in u_latch; reset gives all zeros
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign channel_clear = s_q.clr;
  assign clear_event = s_q.evt;

  enable_gates_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    channel_clear == (clear_event ? s_q.channel_clear_enable
                       : '0) || $changed(s_q.channel_clear_enable))
    else $error("Clear output not gated by enable");
  disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((channel_clear & ~$past(s_q.channel_clear_enable)) == '0))
    else $error("Disabled channel was cleared");
  event_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clear_event == $past(|(flag & select)))
    else $error("Clear event not from selected flags");
  no_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(select) == '0 |-> channel_clear == '0)
    else $error("Channel cleared with no source selected");
  mode_free_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_mode || !auto_mode) && $past(evt_now) |->
      channel_clear == $past(s_q.channel_clear_enable))
    else $error("Clear depends on operating mode");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.src_adc & ~DCG_SRC_ADC_MASK) == '0 &&
    (s_q.src_misc & ~DCG_SRC_MISC_MASK) == '0)
    else $error("Reserved source bit set");
  low_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_write && reg_addr == DCG_CLR_EN_LOW_ADDR |=>
      s_q.channel_clear_enable[HALF-1:0] == $past(reg_wdata))
    else $error("Low enable write lost");
  readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_read && reg_addr == DCG_CLR_SRC_MISC_ADDR |=>
      reg_rdata == $past(s_q.src_misc))
    else $error("Misc source readback wrong");
  adc_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_write && reg_addr == DCG_CLR_SRC_ADC_ADDR |=>
      select[DCG_NUM_ADC-1:0] == $past(reg_wdata[DCG_NUM_ADC-1:0]))
    else $error("Adc source select not applied");
  misc_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select[NA-1:DCG_NUM_ADC] == s_q.src_misc[DCG_NUM_MISC-1:0])
    else $error("Misc select order wrong");
  // Upper enable half must land from the write data too
  high_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_write && reg_addr == DCG_CLR_EN_HIGH_ADDR |=>
      s_q.channel_clear_enable[DCG_NUM_CH-1:HALF] == $past(reg_wdata))
    else $error("High enable write lost");
  // Misc write keeps only the four documented select bits
  misc_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_write && reg_addr == DCG_CLR_SRC_MISC_ADDR |=>
      s_q.src_misc == ($past(reg_wdata) & DCG_SRC_MISC_MASK))
    else $error("Misc source write wrong");
  // No read strobe means the read port shows zero next cycle
  idle_rdata_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_read |=> reg_rdata == DCG_RESET_VAL)
    else $error("Read data not zero when idle");
  // Sticky flags must drop after a status read once conditions are gone
  read_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stat_read && !s_q.alarm_latch_disable && s_q.sync2 == '0 |=>
      flag == '0)
    else $error("Status read did not release flags");
endmodule : dcg_clear_gate

//--- test_dac_alarm_clear_gating.sv
/*
  Self-checking bench for the converter clear gating block.
  Assumes the dcg_pkg register map and a 2-flop alarm sync path.
*/
`timescale 1ns/1ps
module test_dac_alarm_clear_gating;
  import dcg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [8:0] alm = 9'h000;
  logic auto_mode = 1'b0;
  logic [15:0] channel_clear;
  logic clear_event;
  int error_cnt = 0;
  int n_compared = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  dcg_clear_gate DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .input_alarm(alm[4:0]),
    .external_alarm_input_pin(alm[5]), .thermal_alarm(alm[6]),
    .local_temp_high_alarm(alm[7]), .local_temp_low_alarm(alm[8]),
    .auto_mode(auto_mode), .channel_clear(channel_clear),
    .clear_event(clear_event)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // One-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    n_compared++;
    if (reg_rdata !== e) begin
      error_cnt++;
      $display("unexpected at %0t: read %h got %h want %h", $time, a,
               reg_rdata, e);
    end
  endtask : chk_rd

  task automatic chk_out(input logic e_ev, input logic [15:0] e_ch);
    #1;
    n_compared++;
    if (clear_event !== e_ev || channel_clear !== e_ch) begin
      error_cnt++;
      $display("unexpected at %0t: event %b clear %h want %b %h", $time,
               clear_event, channel_clear, e_ev, e_ch);
    end
  endtask : chk_out

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog so a hang still reaches the verdict
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end

  initial begin
    cyc(5);
    rst_n <= 1'b1;
    // Reset values and read-write access
    chk_rd(DCG_CLR_EN_LOW_ADDR, 8'h00);
    chk_rd(DCG_CLR_EN_HIGH_ADDR, 8'h00);
    chk_rd(DCG_CLR_SRC_ADC_ADDR, 8'h00);
    chk_rd(DCG_CLR_SRC_MISC_ADDR, 8'h00);
    wr(DCG_CLR_EN_LOW_ADDR, 8'ha5);
    wr(DCG_CLR_EN_HIGH_ADDR, 8'h3c);
    wr(DCG_CLR_SRC_ADC_ADDR, 8'hff);
    wr(DCG_CLR_SRC_MISC_ADDR, 8'hff);
    wr(8'h30, 8'hff);
    chk_rd(DCG_CLR_EN_LOW_ADDR, 8'ha5);
    chk_rd(DCG_CLR_EN_HIGH_ADDR, 8'h3c);
    chk_rd(DCG_CLR_SRC_ADC_ADDR, 8'h1f);
    chk_rd(DCG_CLR_SRC_MISC_ADDR, 8'h0f);
    chk_rd(8'h30, 8'h00);
    $display("test registers done");
    // Latched flag outlives a short pin pulse until status is read
    wr(DCG_CLR_SRC_ADC_ADDR, 8'h00);
    wr(DCG_CLR_SRC_MISC_ADDR, 8'h08);
    alm <= 9'h020;
    cyc(3);
    alm <= 9'h000;
    cyc(8);
    chk_out(1'b1, 16'h3ca5);
    chk_rd(DCG_ALARM_STAT_HI_ADDR, 8'h01);
    cyc(3);
    chk_out(1'b0, 16'h0000);
    $display("test latch done");
    // Following flags: each source alone, modes alternating
    wr(DCG_CTRL_ADDR, 8'h10);
    chk_rd(DCG_CTRL_ADDR, 8'h10);
    for (int k = 0; k < 9; k++) begin
      wr(DCG_CLR_SRC_ADC_ADDR, k < 5 ? 8'(1 << k) : 8'h00);
      wr(DCG_CLR_SRC_MISC_ADDR, k >= 5 ? 8'(1 << (8 - k)) : 8'h00);
      auto_mode <= k[0];
      alm <= 9'(1 << k);
      cyc(6);
      chk_out(1'b1, 16'h3ca5);
      // Alarm still high but no longer selected
      wr(DCG_CLR_SRC_ADC_ADDR, 8'h00);
      wr(DCG_CLR_SRC_MISC_ADDR, 8'h00);
      cyc(3);
      chk_out(1'b0, 16'h0000);
      alm <= 9'h000;
      cyc(6);
    end
    $display("test sources done");
    // Selected alarm with every channel disabled clears nothing
    wr(DCG_CLR_EN_LOW_ADDR, 8'h00);
    wr(DCG_CLR_EN_HIGH_ADDR, 8'h00);
    wr(DCG_CLR_SRC_MISC_ADDR, 8'h01);
    alm <= 9'h100;
    cyc(6);
    chk_out(1'b1, 16'h0000);
    wr(DCG_CLR_EN_HIGH_ADDR, 8'h80);
    cyc(3);
    chk_out(1'b1, 16'h8000);
    chk_rd(DCG_CLR_STAT_HIGH_ADDR, 8'h80);
    chk_rd(DCG_CLR_STAT_LOW_ADDR, 8'h00);
    chk_rd(DCG_ALARM_STAT_ADDR, 8'h20);
    alm <= 9'h000;
    cyc(6);
    chk_out(1'b0, 16'h0000);
    $display("test enables done");
    end_of_test();
  end
endmodule : test_dac_alarm_clear_gating
